/* File: pss_dec_model.sv */
// Decoder-side model: pair register, status flags and interrupt requests.
// Assumes the sequencer's clock and reset; the bench sets values by strobe.
`timescale 1ns/10ps
module pss_dec_model (
	input  wire logic           ref_clk,
	input  wire logic           rst,
	input  wire logic           set_en,
	input  pss_pkg::pss_addr_t  set_pair,
	input  pss_pkg::pss_flags_t set_flags,
	input  wire logic [2:0]     req_set,
	input  wire logic           ar_load,
	input  pss_pkg::pss_addr_t  ar_data,
	input  wire logic           flags_load,
	input  pss_pkg::pss_flags_t flags_data,
	input  wire logic [2:0]     irq_ack,
	output pss_pkg::pss_addr_t  pair,
	output pss_pkg::pss_flags_t flags,
	output logic [2:0]          req
);
	import pss_pkg::*;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pair <= '0;
			flags <= '0;
			req <= 3'h0;
		end else begin
			req <= (req | req_set) & ~irq_ack;
			if (set_en) begin
				pair <= set_pair;
				flags <= set_flags;
			end
			if (ar_load)
				pair <= ar_data;
			if (flags_load)
				flags <= flags_data;
		end
	end
endmodule

/* File: pss_irq_flag_stack.sv */
// Three-level interrupt flag stack with circular overwrite of the oldest.
// Assumes push and pop never arrive in the same cycle.
`timescale 1ns/10ps
module pss_irq_flag_stack
	import pss_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       clr,
	input  wire logic       push,
	input  pss_pkg::pss_flags_t din,
	input  wire logic       pop,
	output pss_pkg::pss_flags_t top,
	output logic            lost,
	output logic [1:0]      depth
);
	pss_flags_t ent [IFS_DEPTH];
	logic [1:0] wp_r;
	logic [1:0] cnt_r;
	wire  [1:0] wp_inc = (wp_r == IFS_LAST) ? 2'h0 : wp_r + 2'h1;
	wire  [1:0] wp_dec = (wp_r == 2'h0) ? IFS_LAST : wp_r - 2'h1;

	genvar i;
	generate
		for (i = 0; i < IFS_DEPTH; i++) begin : g_ent
			always_ff @(posedge ref_clk) begin
				if (clr)
					ent[i] <= '0;
				else if (push && wp_r == 2'(i))
					ent[i] <= din;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (clr) begin
			wp_r  <= 2'h0;
			cnt_r <= 2'h0;
		end else if (push) begin
			wp_r <= wp_inc;
			if (cnt_r != 2'(IFS_DEPTH))
				cnt_r <= cnt_r + 2'h1;
		end else if (pop) begin
			wp_r <= wp_dec;
			if (cnt_r != 2'h0)
				cnt_r <= cnt_r - 2'h1;
		end
	end

	assign top   = ent[wp_dec];
	assign lost  = push && cnt_r == 2'(IFS_DEPTH);
	assign depth = cnt_r;
endmodule

/* File: pss_pkg.sv */
// Package of the program sequencer: widths, constants, types.
// Assumes one clock, synchronous active-high reset, decoder-driven commands.
package pss_pkg;
	localparam int PC_W = 13;
	localparam int RAS_DEPTH = 5;
	localparam int IFS_DEPTH = 3;
	localparam logic [2:0] SP_RESET = 3'h5;
	localparam logic [2:0] SP_FAULT = 3'h6;
	localparam logic [1:0] IFS_LAST = 2'h2;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] DIRECT_CALL_MASK = 13'h07FF;
	localparam logic [PC_W-1:0] VEC_TIMER8 = 13'h0003;
	localparam logic [PC_W-1:0] VEC_PIN_EDGE = 13'h0002;
	localparam logic [PC_W-1:0] VEC_INTERVAL = 13'h0001;
	localparam int SYSCALL_BLOCK_LSB = 8;
	localparam int SYSCALL_STEP_W = 4;
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_FETCH = 8'h08;
	localparam logic [7:0] OFS_STACK = 8'h0C;
	localparam int EV_W = 4;
	localparam int EV_STACK_FAULT = 0;
	localparam int EV_IFS_LOST = 1;
	localparam int EV_WDT_RESET = 2;
	localparam int EV_IRQ_TAKEN = 3;
	localparam logic [EV_W-1:0] EV_RESET = 4'h0;

	typedef enum logic [3:0] {
		PSS_OP_NEXT, PSS_OP_JUMP, PSS_OP_CALL, PSS_OP_JUMP_REG, PSS_OP_CALL_REG,
		PSS_OP_SYSCALL, PSS_OP_TABLE1, PSS_OP_TABLE2, PSS_OP_RET, PSS_OP_SKIP_EXIT_OP,
		PSS_OP_IRQ_EXIT_OP, PSS_OP_PUSH, PSS_OP_POP, PSS_OP_IRQ
	} pss_op_t;

	typedef struct packed {
		logic            seg;
		logic [PC_W-1:0] pc;
	} pss_addr_t;

	typedef struct packed {
		pss_op_t         op;
		logic [PC_W-1:0] target;
		logic [6:0]      entry;
	} pss_cmd_t;

	typedef struct packed {
		logic bank;
		logic bcd;
		logic cmp;
		logic cy;
		logic z;
		logic ixe;
	} pss_flags_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pss_bus_t;
endpackage

/* File: pss_ras_mem.sv */
// Return address stack storage, five entries, registered read port.
// Assumes the caller blocks writes to indexes outside the stack.
`timescale 1ns/10ps
module pss_ras_mem
	import pss_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      rst,
	input  wire logic      we,
	input  wire logic [2:0] waddr,
	input  pss_pkg::pss_addr_t wdata,
	input  wire logic [2:0] raddr,
	output pss_pkg::pss_addr_t rdata
);
	pss_addr_t mem [RAS_DEPTH];
	pss_addr_t rdata_r;

	genvar i;
	generate
		for (i = 0; i < RAS_DEPTH; i++) begin : g_ent
			always_ff @(posedge ref_clk) begin
				if (rst)
					mem[i] <= '0;
				else if (we && waddr == 3'(i))
					mem[i] <= wdata;
			end
		end
	endgenerate

	// Write-through so a push is visible as the top in the next cycle
	always_ff @(posedge ref_clk) begin
		if (rst)
			rdata_r <= '0;
		else if (we && waddr == raddr)
			rdata_r <= wdata;
		else if (raddr < 3'(RAS_DEPTH))
			rdata_r <= mem[raddr];
		else
			rdata_r <= '0;
	end

	assign rdata = rdata_r;
endmodule

/* File: pss_sequencer.sv */
// Program sequencer: fetch pointer, next-address selection, stacks,
// interrupt vectors, stack fault reset, and a small register port.
// Assumes the decoder issues one command per cycle with cmd_valid.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/10ps
module pss_sequencer (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              wdt_reset,
	input  wire logic              cmd_valid,
	input  pss_pkg::pss_cmd_t      cmd,
	input  wire logic [2:0]        irq_req,
	input  pss_pkg::pss_addr_t     address_pair_register,
	input  pss_pkg::pss_flags_t    status_flags_word,
	input  pss_pkg::pss_bus_t      bus,
	output pss_pkg::pss_addr_t     fetch_pointer,
	output logic                   ar_load,
	output pss_pkg::pss_addr_t     ar_data,
	output logic                   flags_load,
	output pss_pkg::pss_flags_t    flags_data,
	output logic [2:0]             irq_ack,
	output logic                   reset_pull,
	output logic [31:0]            bus_rdata,
	output logic                   irq
);
	import pss_pkg::*;

	// Architectural state
	pss_addr_t  fp_r;
	pss_addr_t  fp_nxt;
	logic [3:0] stack_index_r;
	logic [3:0] stack_index_nxt;
	logic       ar_load_r;
	pss_addr_t  ar_data_r;
	logic       flags_load_r;
	pss_flags_t flags_data_r;
	logic [2:0] irq_ack_r;
	logic       reset_pull_r;

	// Software view
	logic [EV_W-1:0] status_r;
	logic [EV_W-1:0] status_nxt;
	logic [EV_W-1:0] mask_r;
	logic [31:0]     rdata_r;
	logic            irq_r;

	// Stack plumbing
	pss_addr_t  ras_top;
	pss_addr_t  ras_wdata;
	logic       ras_we;
	pss_flags_t ifs_top;
	logic       ifs_lost;
	logic [1:0] ifs_depth;

	// Command decode
	wire op_jump     = cmd_valid && cmd.op == PSS_OP_JUMP;
	wire op_call     = cmd_valid && cmd.op == PSS_OP_CALL;
	wire op_jump_reg = cmd_valid && cmd.op == PSS_OP_JUMP_REG;
	wire op_call_reg = cmd_valid && cmd.op == PSS_OP_CALL_REG;
	wire op_syscall  = cmd_valid && cmd.op == PSS_OP_SYSCALL;
	wire op_table1   = cmd_valid && cmd.op == PSS_OP_TABLE1;
	wire op_table2   = cmd_valid && cmd.op == PSS_OP_TABLE2;
	wire op_ret      = cmd_valid && cmd.op == PSS_OP_RET;
	wire op_skip_exit_op    = cmd_valid && cmd.op == PSS_OP_SKIP_EXIT_OP;
	wire op_irq_exit_op     = cmd_valid && cmd.op == PSS_OP_IRQ_EXIT_OP;
	wire op_push     = cmd_valid && cmd.op == PSS_OP_PUSH;
	wire op_pop      = cmd_valid && cmd.op == PSS_OP_POP;
	wire op_irq_cmd  = cmd_valid && cmd.op == PSS_OP_IRQ;
	wire op_next     = cmd_valid && cmd.op == PSS_OP_NEXT;

	// An acknowledge with no pending request is ignored
	wire irq_take = op_irq_cmd && (|irq_req);

	// Stack index movement
	wire push_ret  = op_call || op_call_reg || op_syscall || op_table1;
	wire stk_push  = push_ret || op_push || irq_take;
	wire stk_pop   = op_ret || op_skip_exit_op || op_irq_exit_op || op_table2 || op_pop;

	wire [2:0] sp_low  = stack_index_r[2:0];
	wire [2:0] sp_dec  = sp_low - 3'h1;
	wire [2:0] sp_inc  = sp_low + 3'h1;
	wire [2:0] sp_move = stk_push ? sp_dec : (stk_pop ? sp_inc : sp_low);

	// Index stays in 0..7; any value of 6 or more means nesting fault
	wire stack_fault = sp_move >= SP_FAULT;
	wire soft_reset  = stack_fault || wdt_reset;

	assign stack_index_nxt = soft_reset ? {1'b0, SP_RESET} : {1'b0, sp_move};

	// Return address is the following step in the same segment
	wire [PC_W-1:0] pc_inc = fp_r.pc + 13'h0001;
	wire pss_addr_t ret_addr = '{seg: fp_r.seg, pc: pc_inc};

	// Interrupt vector by fixed priority
	wire [PC_W-1:0] irq_vec = irq_req[0] ? VEC_TIMER8 :
		(irq_req[1] ? VEC_PIN_EDGE : VEC_INTERVAL);
	wire [2:0] irq_onehot = irq_req[0] ? 3'h1 :
		(irq_req[1] ? 3'h2 : 3'h4);

	// System call target: segment 1, page 0, block, first 16 steps
	wire [PC_W-1:0] sys_target = {2'h0, cmd.entry[6:4], 4'h0, cmd.entry[SYSCALL_STEP_W-1:0]};

	// Direct call is confined to the low 2K words
	wire [PC_W-1:0] call_target = cmd.target & DIRECT_CALL_MASK;

	// Stack write: pair register on push, current pointer on interrupt, else return address
	assign ras_we    = stk_push && !stack_fault;
	assign ras_wdata = op_push ? address_pair_register :
		(irq_take ? fp_r : ret_addr);

	// Next fetch pointer
	always_comb begin
		fp_nxt = fp_r;
		if (op_jump) begin
			fp_nxt.pc = cmd.target;
		end else if (op_call) begin
			fp_nxt.pc = call_target;
		end else if (op_jump_reg || op_call_reg) begin
			fp_nxt = address_pair_register;
		end else if (op_table1) begin
			fp_nxt.pc = address_pair_register.pc;
		end else if (op_syscall) begin
			fp_nxt.seg = 1'b1;
			fp_nxt.pc  = sys_target;
		end else if (op_ret || op_irq_exit_op || op_table2) begin
			fp_nxt = ras_top;
		end else if (op_skip_exit_op) begin
			fp_nxt.seg = ras_top.seg;
			fp_nxt.pc  = ras_top.pc + 13'h0001;
		end else if (irq_take) begin
			fp_nxt.seg = 1'b0;
			fp_nxt.pc  = irq_vec;
		end else if (op_next || op_push || op_pop) begin
			// Plain step, push and pop advance to the following step
			fp_nxt.pc = pc_inc;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || soft_reset)
			fp_r <= '{seg: 1'b0, pc: PC_RESET};
		else
			fp_r <= fp_nxt;
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			stack_index_r <= {1'b0, SP_RESET};
		else
			stack_index_r <= stack_index_nxt;
	end

	pss_ras_mem u_ras (
		.ref_clk (ref_clk),
		.rst     (rst),
		.we      (ras_we),
		.waddr   (sp_dec),
		.wdata   (ras_wdata),
		.raddr   (stack_index_nxt[2:0]),
		.rdata   (ras_top)
	);

	pss_irq_flag_stack u_ifs (
		.ref_clk (ref_clk),
		.clr     (rst || soft_reset),
		.push    (irq_take && !stack_fault),
		.din     (status_flags_word),
		.pop     (op_irq_exit_op && !stack_fault),
		.top     (ifs_top),
		.lost    (ifs_lost),
		.depth   (ifs_depth)
	);

	// Pop to pair register and flag restore
	always_ff @(posedge ref_clk) begin
		if (rst || soft_reset) begin
			ar_load_r    <= 1'b0;
			ar_data_r    <= '0;
			flags_load_r <= 1'b0;
			flags_data_r <= '0;
			irq_ack_r    <= 3'h0;
		end else begin
			ar_load_r    <= op_pop;
			ar_data_r    <= op_pop ? ras_top : ar_data_r;
			flags_load_r <= op_irq_exit_op;
			flags_data_r <= op_irq_exit_op ? ifs_top : flags_data_r;
			irq_ack_r    <= irq_take ? irq_onehot : 3'h0;
		end
	end

	// Internal pull on the reset line, one cycle per fault
	always_ff @(posedge ref_clk) begin
		if (rst)
			reset_pull_r <= 1'b0;
		else
			reset_pull_r <= stack_fault;
	end

	// Event capture: a set in the clearing cycle wins
	wire [EV_W-1:0] ev_set;
	assign ev_set[EV_STACK_FAULT] = stack_fault;
	assign ev_set[EV_IFS_LOST]    = ifs_lost && irq_take && !stack_fault;
	assign ev_set[EV_WDT_RESET]   = wdt_reset;
	assign ev_set[EV_IRQ_TAKEN]   = irq_take && !stack_fault;

	wire wr_status = bus.wr && bus.addr == OFS_STATUS;
	wire wr_mask   = bus.wr && bus.addr == OFS_MASK;
	wire [EV_W-1:0] ev_clr = wr_status ? bus.wdata[EV_W-1:0] : '0;

	assign status_nxt = (status_r & ~ev_clr) | ev_set;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status_r <= EV_RESET;
			mask_r   <= EV_RESET;
		end else begin
			status_r <= status_nxt;
			mask_r   <= wr_mask ? bus.wdata[EV_W-1:0] : mask_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			irq_r <= 1'b0;
		else
			irq_r <= |(status_nxt & (wr_mask ? bus.wdata[EV_W-1:0] : mask_r));
	end

	// Read decode
	wire [31:0] rd_status = {28'h0, status_r};
	wire [31:0] rd_mask   = {28'h0, mask_r};
	wire [31:0] rd_fetch  = {18'h0, fp_r};
	wire [31:0] rd_stack  = {26'h0, ifs_depth, stack_index_r};
	wire [31:0] rd_mux;
	assign rd_mux = (bus.addr == OFS_STATUS) ? rd_status :
		(bus.addr == OFS_MASK)  ? rd_mask :
		(bus.addr == OFS_FETCH) ? rd_fetch :
		(bus.addr == OFS_STACK) ? rd_stack : 32'h0;

	always_ff @(posedge ref_clk) begin
		if (rst)
			rdata_r <= 32'h0;
		else
			rdata_r <= bus.rd ? rd_mux : 32'h0;
	end

	assign fetch_pointer = fp_r;
	assign ar_load       = ar_load_r;
	assign ar_data       = ar_data_r;
	assign flags_load    = flags_load_r;
	assign flags_data    = flags_data_r;
	assign irq_ack       = irq_ack_r;
	assign reset_pull    = reset_pull_r;
	assign bus_rdata     = rdata_r;
	assign irq           = irq_r;
endmodule

/* File: pss_sequencer_sva.sv */
// Checker of the sequencer's next-address choice, vectors and fault reset.
// Assumes it is bound to the sequencer and sees its ports only.
`timescale 1ns/10ps
module pss_sequencer_sva (
	input wire logic          ref_clk,
	input wire logic          rst,
	input wire logic          wdt_reset,
	input wire logic          cmd_valid,
	input pss_pkg::pss_cmd_t  cmd,
	input wire logic [2:0]    irq_req,
	input pss_pkg::pss_addr_t address_pair_register,
	input pss_pkg::pss_addr_t fetch_pointer,
	input wire logic [2:0]    irq_ack,
	input wire logic          reset_pull
);
	import pss_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire go;
	assign go = cmd_valid && !wdt_reset;
	property p_wdt;
		wdt_reset |=> fetch_pointer == 14'h0000;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog did not clear fetch pointer");
	property p_pull;
		reset_pull |-> fetch_pointer == 14'h0000;
	endproperty
	a_pull: assert property (p_pull) else $error("fault reset left fetch pointer");
	property p_next;
		go && cmd.op == PSS_OP_NEXT |=> fetch_pointer.pc == $past(fetch_pointer.pc) + 13'h0001
			&& fetch_pointer.seg == $past(fetch_pointer.seg);
	endproperty
	a_next: assert property (p_next) else $error("plain step wrong");
	property p_jump;
		go && cmd.op == PSS_OP_JUMP |=> fetch_pointer.pc == $past(cmd.target) && $stable(fetch_pointer.seg);
	endproperty
	a_jump: assert property (p_jump) else $error("direct jump wrong");
	property p_jreg;
		go && cmd.op == PSS_OP_JUMP_REG |=> fetch_pointer == $past(address_pair_register);
	endproperty
	a_jreg: assert property (p_jreg) else $error("register jump wrong");
	property p_call;
		go && cmd.op == PSS_OP_CALL |=> reset_pull || fetch_pointer.pc == ($past(cmd.target) & DIRECT_CALL_MASK);
	endproperty
	a_call: assert property (p_call) else $error("direct call reach wrong");
	property p_sys;
		go && cmd.op == PSS_OP_SYSCALL |=> reset_pull
			|| fetch_pointer == {1'b1, 2'b00, $past(cmd.entry[6:4]), 4'h0, $past(cmd.entry[3:0])};
	endproperty
	a_sys: assert property (p_sys) else $error("system call target wrong");
	property p_irq0;
		go && cmd.op == PSS_OP_IRQ && irq_req[0] |=> reset_pull
			|| fetch_pointer == {1'b0, VEC_TIMER8} && irq_ack == 3'h1;
	endproperty
	a_irq0: assert property (p_irq0) else $error("timer vector wrong");
	property p_irq1;
		go && cmd.op == PSS_OP_IRQ && irq_req[1:0] == 2'b10 |=> reset_pull
			|| fetch_pointer == {1'b0, VEC_PIN_EDGE} && irq_ack == 3'h2;
	endproperty
	a_irq1: assert property (p_irq1) else $error("pin edge vector wrong");
	property p_irq2;
		go && cmd.op == PSS_OP_IRQ && irq_req == 3'h4 |=> reset_pull
			|| fetch_pointer == {1'b0, VEC_INTERVAL} && irq_ack == 3'h4;
	endproperty
	a_irq2: assert property (p_irq2) else $error("interval vector wrong");
	property p_irqnone;
		go && cmd.op == PSS_OP_IRQ && irq_req == 3'h0 |=> $stable(fetch_pointer) && irq_ack == 3'h0;
	endproperty
	a_irqnone: assert property (p_irqnone) else $error("ignored acknowledge moved fetch pointer");
endmodule
bind pss_sequencer pss_sequencer_sva u_sva (.ref_clk(ref_clk), .rst(rst), .wdt_reset(wdt_reset),
	.cmd_valid(cmd_valid), .cmd(cmd), .irq_req(irq_req), .address_pair_register(address_pair_register),
	.fetch_pointer(fetch_pointer), .irq_ack(irq_ack), .reset_pull(reset_pull));

/* File: pss_sequencer_tb.sv */
// Bench of the program sequencer driven through commands and register port.
// Assumes the decoder model on the command side and the bound checker.
`timescale 1ns/10ps
module pss_sequencer_tb;
	import pss_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, wdt_reset = 1'b0, cmd_valid = 1'b0, set_en = 1'b0;
	pss_cmd_t cmd = '0;
	pss_bus_t bus = '0;
	pss_addr_t set_pair = '0, pair, fetch_pointer, ar_data;
	pss_flags_t set_flags = '0, flags, flags_data;
	logic [2:0] req_set = 3'h0, req, irq_ack;
	logic ar_load, flags_load, reset_pull, irq;
	logic [31:0] bus_rdata;
	int failures = 0, cmp_count = 0, cycles = 0;
	pss_dec_model u_dec (.ref_clk(ref_clk), .rst(rst), .set_en(set_en), .set_pair(set_pair),
		.set_flags(set_flags), .req_set(req_set), .ar_load(ar_load), .ar_data(ar_data),
		.flags_load(flags_load), .flags_data(flags_data), .irq_ack(irq_ack), .pair(pair),
		.flags(flags), .req(req));
	pss_sequencer DUT (.ref_clk(ref_clk), .rst(rst), .wdt_reset(wdt_reset), .cmd_valid(cmd_valid),
		.cmd(cmd), .irq_req(req), .address_pair_register(pair), .status_flags_word(flags), .bus(bus),
		.fetch_pointer(fetch_pointer), .ar_load(ar_load), .ar_data(ar_data), .flags_load(flags_load),
		.flags_data(flags_data), .irq_ack(irq_ack), .reset_pull(reset_pull), .bus_rdata(bus_rdata),
		.irq(irq));
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic final_report();
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic fchk(input logic [13:0] e);
		chk({18'h0, fetch_pointer}, {18'h0, e});
	endtask
	// Command taken at the second edge; results settle just after it
	task automatic op(input pss_op_t o, input logic [12:0] t = 13'h0000, input logic [6:0] e = 7'h00);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: o, target: t, entry: e};
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		#1;
	endtask
	task automatic access(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge ref_clk);
		bus <= '0;
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		access(a, 32'h0, 1'b0);
		chk(bus_rdata, e);
	endtask
	task automatic setp(input pss_addr_t p, input pss_flags_t f);
		@(posedge ref_clk);
		set_en <= 1'b1;
		set_pair <= p;
		set_flags <= f;
		@(posedge ref_clk);
		set_en <= 1'b0;
	endtask
	task automatic raise(input logic [2:0] r);
		@(posedge ref_clk);
		req_set <= r;
		@(posedge ref_clk);
		req_set <= 3'h0;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rchk(OFS_FETCH, 32'h0);
		rchk(OFS_STACK, 32'h5);
		rchk(8'h10, 32'h0);
		repeat (3) op(PSS_OP_NEXT);
		fchk(14'h0003);
		op(PSS_OP_JUMP, 13'h1ABC);
		fchk(14'h1ABC);
		op(PSS_OP_CALL, 13'h1FFF);
		fchk(14'h07FF);
		rchk(OFS_STACK, 32'h4);
		op(PSS_OP_RET);
		fchk(14'h1ABD);
		setp({1'b1, 13'h1234}, 6'h2A);
		op(PSS_OP_JUMP_REG);
		fchk(14'h3234);
		op(PSS_OP_NEXT);
		fchk(14'h3235);
		op(PSS_OP_JUMP, 13'h0100);
		fchk(14'h2100);
		op(PSS_OP_CALL_REG);
		fchk(14'h3234);
		op(PSS_OP_SKIP_EXIT_OP);
		fchk(14'h2102);
		setp({1'b0, 13'h0FF0}, 6'h2A);
		op(PSS_OP_JUMP_REG);
		op(PSS_OP_SYSCALL, 13'h0000, 7'h5A);
		fchk(14'h250A);
		op(PSS_OP_RET);
		fchk(14'h0FF1);
		setp({1'b1, 13'h1777}, 6'h15);
		op(PSS_OP_TABLE1);
		fchk(14'h1777);
		op(PSS_OP_TABLE2);
		fchk(14'h0FF2);
		op(PSS_OP_PUSH);
		op(PSS_OP_POP);
		chk(ar_load, 1'b1);
		chk(ar_data, 14'h3777);
		rchk(OFS_STACK, 32'h5);
		access(OFS_MASK, 32'h8, 1'b1);
		op(PSS_OP_IRQ);
		fchk(14'h0FF4);
		raise(3'h3);
		op(PSS_OP_IRQ);
		fchk(14'h0003);
		chk(irq_ack, 3'h1);
		chk(irq, 1'b1);
		setp({1'b1, 13'h1777}, 6'h0A);
		op(PSS_OP_IRQ);
		fchk(14'h0002);
		setp({1'b1, 13'h1777}, 6'h33);
		raise(3'h4);
		op(PSS_OP_IRQ);
		fchk(14'h0001);
		op(PSS_OP_IRQ_EXIT_OP);
		fchk(14'h0002);
		chk(flags_load, 1'b1);
		chk(flags_data, 6'h33);
		op(PSS_OP_IRQ_EXIT_OP);
		chk(flags_data, 6'h0A);
		op(PSS_OP_IRQ_EXIT_OP);
		fchk(14'h0FF4);
		chk(flags_data, 6'h15);
		access(OFS_STATUS, 32'hF, 1'b1);
		chk(irq, 1'b0);
		for (int k = 1; k <= 4; k++) begin
			setp({1'b1, 13'h1777}, 6'(k));
			raise(3'h1);
			op(PSS_OP_IRQ);
		end
		rchk(OFS_STATUS, 32'hA);
		for (int k = 4; k >= 2; k--) begin
			op(PSS_OP_IRQ_EXIT_OP);
			chk(flags_data, 32'(k));
		end
		repeat (5) op(PSS_OP_PUSH);
		chk(reset_pull, 1'b1);
		fchk(14'h0000);
		rchk(OFS_STACK, 32'h5);
		rchk(OFS_STATUS, 32'hB);
		setp({1'b1, 13'h1000}, 6'h00);
		op(PSS_OP_JUMP_REG);
		@(posedge ref_clk);
		wdt_reset <= 1'b1;
		@(posedge ref_clk);
		wdt_reset <= 1'b0;
		#1;
		fchk(14'h0000);
		rchk(OFS_STATUS, 32'hF);
		op(PSS_OP_POP);
		chk(reset_pull, 1'b1);
		rchk(OFS_STACK, 32'h5);
		final_report();
	end
endmodule
